/* logic/nco_pkg.sv */
// shared constants for the oscillator control block and its host
package nco_pkg;
  // serial word layout
  localparam int NCO_WORD_W = 16;
  localparam logic [1:0] NCO_ADDR_CTRL = 2'h0;
  localparam logic [1:0] NCO_ADDR_FREQ_WORD_ZERO = 2'h1;
  localparam logic [1:0] NCO_ADDR_FREQ_WORD_ONE = 2'h2;
  localparam logic [1:0] NCO_ADDR_PHASE = 2'h3;
  localparam int NCO_HALF_W = 14;
  localparam int NCO_PHASE_SEL_POS = 13;
  // control word field positions
  localparam int NCO_FULL_WORD_POS = 13;
  localparam int NCO_HALF_HIGH_POS = 12;
  localparam int NCO_FREQ_SELECT_BIT_POS = 11;
  localparam int NCO_PSEL_POS = 10;
  localparam int NCO_SRC_POS = 9;
  localparam int NCO_DAC_PD_POS = 6;
  localparam int NCO_SQ_EN_POS = 5;
  localparam int NCO_SQ_SRC_POS = 4;
  localparam int NCO_HALVE_POS = 3;
  localparam int NCO_MODE_POS = 1;
  localparam int NCO_RSVD_HI_POS = 2;
  localparam int NCO_RSVD_LO_POS = 0;
  // datapath widths
  localparam int NCO_FREQ_W = 28;
  localparam int NCO_PHASE_W = 12;
  localparam int NCO_DAC_W = 10;
  // reset values
  localparam logic [15:0] NCO_CTRL_RST = 16'h0000;
  localparam logic [27:0] NCO_FREQ_RST = 28'h0000000;
  localparam logic [11:0] NCO_PHASE_RST = 12'h000;
  // host register offsets (byte addresses)
  localparam logic [31:0] NCO_HOST_WORD_OFS = 32'h0000_0000;
  localparam logic [31:0] NCO_HOST_PINS_OFS = 32'h0000_0004;
  localparam logic [31:0] NCO_HOST_COUNT_OFS = 32'h0000_0008;
  localparam int NCO_PIN_FREQ_SELECT_BIT_POS = 0;
  localparam int NCO_PIN_PSEL_POS = 1;
  // ahb-lite encodings
  localparam logic [1:0] NCO_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] NCO_HSIZE_WORD = 3'h2;
endpackage

/* logic/nco_link_if.sv */
// link between host controller and oscillator device
`timescale 1ns/10ps
interface nco_link_if;
  logic [15:0] word_data;
  logic word_valid;
  logic freq_select_pin;
  logic phase_select_pin;
  modport device_mp (
    input word_data,
    input word_valid,
    input freq_select_pin,
    input phase_select_pin
  );
  modport host_mp (
    output word_data,
    output word_valid,
    output freq_select_pin,
    output phase_select_pin
  );
endinterface

/* logic/nco_sync2.sv */
// two-flop level synchroniser
`timescale 1ns/10ps
module nco_sync2
(
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* logic/nco_device.sv */
// oscillator device: control word, tuning registers, output logic
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - powerdown bit turns DAC off
// - enable bit drives square pin, else released
// - host keeps enable low when pin unused
// - source bit picks comparator or DAC MSB
// - halving bit: 1 direct, 0 halved
// - host writes reserved bits as zero
// - mode bit: ramp bypass, else sine
// - host clears mode when enable set
// - two 28-bit and two 12-bit registers
// - accumulator adds selected word every cycle
// - selected phase offset added, 4096 steps
// - source bit picks pins or control bits
// - select pins sampled by clock
// - pin change applies two cycles later, after the two-flop synchroniser
// - host holds pins steady in bit mode
// - select source switchable any time
// - top bits 00 write control word
// - top bits 01/10 write frequency words
// - top bits 11 write phase register
// - full-word mode commits after both halves
module nco_device
  import nco_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  nco_link_if.device_mp link,
  input wire logic comparator_in,
  output logic [NCO_DAC_W-1:0] dac_data,
  output logic dac_powerdown,
  output logic square_out,
  output logic square_out_oe_n,
  output logic [NCO_FREQ_W-1:0] phase_acc
);
  logic [15:0] ctrl_q;
  logic [NCO_FREQ_W-1:0] freq_word_zero_q;
  logic [NCO_FREQ_W-1:0] freq_word_one_q;
  logic [NCO_PHASE_W-1:0] phase_offset_zero_q;
  logic [NCO_PHASE_W-1:0] phase_offset_one_q;
  logic [NCO_HALF_W-1:0] low_half_q;
  logic pending_q;
  logic [1:0] pending_addr_q;
  logic [NCO_FREQ_W-1:0] acc_q;
  logic [NCO_DAC_W-1:0] dac_q;
  logic msb_prev_q;
  logic msb_half_q;
  logic fpin_s;
  logic ppin_s;
  logic comp_s;
  logic [1:0] addr;
  logic [NCO_HALF_W-1:0] half;
  logic freq_write;
  logic full_word;
  logic half_high;
  logic use_one_freq;
  logic use_one_phase;
  logic [NCO_FREQ_W-1:0] active_freq_word;
  logic [NCO_PHASE_W-1:0] active_phase_word;
  logic [NCO_PHASE_W-1:0] phase_sum;
  logic [NCO_DAC_W-1:0] wave;
  logic sq_bit;

  // merge a 14-bit half into a frequency word
  function automatic logic [NCO_FREQ_W-1:0] merge_half(
    input logic [NCO_FREQ_W-1:0] old,
    input logic [NCO_HALF_W-1:0] h,
    input logic high
  );
    merge_half = high ? {h, old[NCO_HALF_W-1:0]}
                      : {old[NCO_FREQ_W-1:NCO_HALF_W], h};
  endfunction

  // parabolic sine approximation of a 12-bit phase
  function automatic logic [NCO_DAC_W-1:0] sine_lookup(
    input logic [NCO_PHASE_W-1:0] p
  );
    logic [10:0] x;
    logic [21:0] prod;
    logic [9:0] mag;
    x = p[10:0];
    prod = {11'h000, x} * {10'h000, 12'h800 - {1'b0, x}};
    mag = prod[20] ? 10'h1FF : {1'b0, prod[19:11]};
    sine_lookup = p[11] ? 10'h200 - mag : 10'h200 + mag;
  endfunction

  // pins from outside the clock domain
  nco_sync2 u_freq_select_bit_sync (
    .clock(clock),
    .rst(rst),
    .async_in(link.freq_select_pin),
    .sync_out(fpin_s)
  );
  nco_sync2 u_psel_sync (
    .clock(clock),
    .rst(rst),
    .async_in(link.phase_select_pin),
    .sync_out(ppin_s)
  );
  nco_sync2 u_comp_sync (
    .clock(clock),
    .rst(rst),
    .async_in(comparator_in),
    .sync_out(comp_s)
  );

  // word decode
  assign addr = link.word_data[15:14];
  assign half = link.word_data[NCO_HALF_W-1:0];
  assign freq_write = link.word_valid
                      && (addr == NCO_ADDR_FREQ_WORD_ZERO || addr == NCO_ADDR_FREQ_WORD_ONE);
  assign full_word = ctrl_q[NCO_FULL_WORD_POS];
  assign half_high = ctrl_q[NCO_HALF_HIGH_POS];

  // control word, reserved bits stored as given
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_q <= NCO_CTRL_RST;
    else if (link.word_valid && addr == NCO_ADDR_CTRL)
      ctrl_q <= {2'h0, link.word_data[13:0]};
  end

  // full-word half tracking
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pending_q <= 1'b0;
      pending_addr_q <= NCO_ADDR_CTRL;
      low_half_q <= '0;
    end
    else if (link.word_valid)
    begin
      if (freq_write && full_word
          && !(pending_q && pending_addr_q == addr))
      begin
        pending_q <= 1'b1;
        pending_addr_q <= addr;
        low_half_q <= half;
      end
      else
        pending_q <= 1'b0;
    end
  end

  // frequency registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      freq_word_zero_q <= NCO_FREQ_RST;
      freq_word_one_q <= NCO_FREQ_RST;
    end
    else if (freq_write)
    begin
      if (full_word)
      begin
        if (pending_q && pending_addr_q == addr)
        begin
          if (addr == NCO_ADDR_FREQ_WORD_ZERO)
            freq_word_zero_q <= {half, low_half_q};
          else
            freq_word_one_q <= {half, low_half_q};
        end
      end
      else if (addr == NCO_ADDR_FREQ_WORD_ZERO)
        freq_word_zero_q <= merge_half(freq_word_zero_q, half,
                                       half_high);
      else
        freq_word_one_q <= merge_half(freq_word_one_q, half,
                                      half_high);
    end
  end

  // phase registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase_offset_zero_q <= NCO_PHASE_RST;
      phase_offset_one_q <= NCO_PHASE_RST;
    end
    else if (link.word_valid && addr == NCO_ADDR_PHASE)
    begin
      if (link.word_data[NCO_PHASE_SEL_POS])
        phase_offset_one_q <= link.word_data[NCO_PHASE_W-1:0];
      else
        phase_offset_zero_q <= link.word_data[NCO_PHASE_W-1:0];
    end
  end

  // register selection from pins or bits
  assign use_one_freq = ctrl_q[NCO_SRC_POS] ? fpin_s
                                            : ctrl_q[NCO_FREQ_SELECT_BIT_POS];
  assign use_one_phase = ctrl_q[NCO_SRC_POS] ? ppin_s
                                             : ctrl_q[NCO_PSEL_POS];
  assign active_freq_word = use_one_freq ? freq_word_one_q
                                         : freq_word_zero_q;
  assign active_phase_word = use_one_phase ? phase_offset_one_q
                                           : phase_offset_zero_q;

  // phase accumulator
  always_ff @(posedge clock)
  begin
    if (rst)
      acc_q <= NCO_FREQ_RST;
    else
      acc_q <= acc_q + active_freq_word;
  end

  // offset phase, ramp or sine
  assign phase_sum = acc_q[NCO_FREQ_W-1 -: NCO_PHASE_W]
                     + active_phase_word;
  assign wave = ctrl_q[NCO_MODE_POS] ? phase_sum[NCO_PHASE_W-1 -: NCO_DAC_W]
                                     : sine_lookup(phase_sum);

  // dac data and power-down
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dac_q <= '0;
      dac_powerdown <= 1'b0;
    end
    else
    begin
      dac_q <= wave;
      dac_powerdown <= ctrl_q[NCO_DAC_PD_POS];
    end
  end

  // msb divided by two
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      msb_prev_q <= 1'b0;
      msb_half_q <= 1'b0;
    end
    else
    begin
      msb_prev_q <= dac_q[NCO_DAC_W-1];
      if (dac_q[NCO_DAC_W-1] && !msb_prev_q)
        msb_half_q <= ~msb_half_q;
    end
  end

  // square pin source
  assign sq_bit = ctrl_q[NCO_SQ_SRC_POS] ? comp_s
                : ctrl_q[NCO_HALVE_POS] ? dac_q[NCO_DAC_W-1]
                : msb_half_q;

  // square pin drive and enable
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      square_out <= 1'b0;
      square_out_oe_n <= 1'b1;
    end
    else
    begin
      square_out <= ctrl_q[NCO_SQ_EN_POS] ? sq_bit : 1'b0;
      square_out_oe_n <= ~ctrl_q[NCO_SQ_EN_POS];
    end
  end

  assign dac_data = dac_q;
  assign phase_acc = acc_q;
endmodule

/* logic/nco_host.sv */
// host controller: ahb-lite registers driving the oscillator link
`timescale 1ns/10ps
module nco_host
  import nco_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  nco_link_if.host_mp link
);
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [15:0] word_q;
  logic word_valid_q;
  logic fpin_q;
  logic ppin_q;
  logic [15:0] count_q;
  logic take;

  // control words leave with reserved bits clear, ramp off with pin on
  function automatic logic [15:0] ctrl_safe(input logic [15:0] w);
    ctrl_safe = w;
    if (w[15:14] == NCO_ADDR_CTRL)
    begin
      ctrl_safe[NCO_RSVD_HI_POS] = 1'b0;
      ctrl_safe[NCO_RSVD_LO_POS] = 1'b0;
      if (w[NCO_SQ_EN_POS])
        ctrl_safe[NCO_MODE_POS] = 1'b0;
    end
  endfunction

  // address phase acceptance, whole-word transfers only
  assign take = hsel && hready && htrans == NCO_HTRANS_NONSEQ
                && hsize == NCO_HSIZE_WORD;

  // address phase capture
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      if (take)
        addr_q <= haddr;
    end
  end

  // write data phase: words go out as one-cycle strobes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      word_q <= '0;
      word_valid_q <= 1'b0;
      fpin_q <= 1'b0;
      ppin_q <= 1'b0;
    end
    else
    begin
      word_valid_q <= 1'b0;
      if (wr_pend_q)
      begin
        if (addr_q == NCO_HOST_WORD_OFS)
        begin
          word_q <= ctrl_safe(hwdata[15:0]);
          word_valid_q <= 1'b1;
        end
        else if (addr_q == NCO_HOST_PINS_OFS)
        begin
          fpin_q <= hwdata[NCO_PIN_FREQ_SELECT_BIT_POS];
          ppin_q <= hwdata[NCO_PIN_PSEL_POS];
        end
      end
    end
  end

  // count of words sent
  always_ff @(posedge clock)
  begin
    if (rst)
      count_q <= '0;
    else if (word_valid_q)
      count_q <= count_q + 16'h0001;
  end

  // read data, registered at the address phase
  always_ff @(posedge clock)
  begin
    if (rst)
      hrdata <= '0;
    else if (take && !hwrite)
    begin
      if (haddr == NCO_HOST_WORD_OFS)
        hrdata <= {16'h0000, word_q};
      else if (haddr == NCO_HOST_PINS_OFS)
        hrdata <= {30'h0, ppin_q, fpin_q};
      else if (haddr == NCO_HOST_COUNT_OFS)
        hrdata <= {16'h0000, count_q};
      else
        hrdata <= '0;
    end
  end

  // zero-wait, always okay
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign link.word_data = word_q;
  assign link.word_valid = word_valid_q;
  assign link.freq_select_pin = fpin_q;
  assign link.phase_select_pin = ppin_q;
endmodule

/* dv/nco_link_properties.sv */
// concurrent checks on the link and the device outputs
`timescale 1ns/10ps
module nco_link_props
  import nco_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  input wire logic dac_powerdown,
  input wire logic square_out,
  input wire logic square_out_oe_n,
  input wire logic [NCO_FREQ_W-1:0] phase_acc
);
  logic ctrl_wr;
  logic fw_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // control word seen on the link
  assign ctrl_wr = word_valid && word_data[15:14] == NCO_ADDR_CTRL;
  // set once any frequency word has arrived
  always_ff @(posedge clock)
  begin
    if (rst)
      fw_q <= 1'b0;
    else if (word_valid && ^word_data[15:14])
      fw_q <= 1'b1;
  end
  pd_follow_a:
    assert property (ctrl_wr |-> ##2
      dac_powerdown == $past(word_data[NCO_DAC_PD_POS], 2))
    else $error("powerdown not following control bit");
  sq_enable_a:
    assert property (ctrl_wr |-> ##2
      square_out_oe_n == !$past(word_data[NCO_SQ_EN_POS], 2))
    else $error("square pin enable not following control bit");
  sq_idle_a:
    assert property (square_out_oe_n |-> !square_out)
    else $error("square pin active while released");
  out_hold_a:
    assert property (!ctrl_wr |-> ##2
      ($stable(dac_powerdown) && $stable(square_out_oe_n)))
    else $error("control outputs moved without control word");
  reset_state_a:
    assert property ($fell(rst) |-> square_out_oe_n && !dac_powerdown
      && !word_valid && phase_acc == '0)
    else $error("outputs not cleared by reset");
  acc_frozen_a:
    assert property (!fw_q |=> $stable(phase_acc))
    else $error("accumulator moved with zero frequency words");
  word_hold_a:
    assert property ($changed(word_data) |-> word_valid)
    else $error("link word changed without strobe");
  valid_pulse_a:
    assert property (word_valid |=> !word_valid)
    else $error("link strobe longer than one cycle");
endmodule

/* dv/tb_nco_control_and_register_select.sv */
// self-checking bench for the host and device pair
`timescale 1ns/10ps
module tb_nco_control_and_register_select
  import nco_pkg::*;
  ;
  logic clock, rst, hsel, hwrite, comparator_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, dac_powerdown, square_out, square_out_oe_n;
  logic [NCO_DAC_W-1:0] dac_data;
  logic [NCO_FREQ_W-1:0] phase_acc, f0, f1;
  logic [11:0] p0, p1;
  logic [15:0] sentq[$];
  logic dp, sp, r1, r2;
  int err_count, checked;
  nco_link_if link();
  nco_host u_nco_host (.clock, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .link);
  nco_device u_nco_device (.clock, .rst, .link, .comparator_in,
    .dac_data, .dac_powerdown, .square_out, .square_out_oe_n, .phase_acc);
  nco_link_props u_props (.clock, .rst, .word_data(link.word_data),
    .word_valid(link.word_valid), .dac_powerdown, .square_out,
    .square_out_oe_n, .phase_acc);
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one single ahb transfer, read data left in rd
  task automatic ahb(input logic [31:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= NCO_HTRANS_NONSEQ;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // push one link word through the host
  task automatic send(input logic [15:0] w);
    logic [15:0] e;
    ahb(NCO_HOST_WORD_OFS, 1'b1, {16'h0, w});
    e = w;
    if (w[15:14] == NCO_ADDR_CTRL)
    begin
      e[NCO_RSVD_HI_POS] = 1'b0;
      e[NCO_RSVD_LO_POS] = 1'b0;
      if (e[NCO_SQ_EN_POS])
        e[NCO_MODE_POS] = 1'b0;
    end
    sentq.push_back(e);
  endtask
  // accumulator step over one cycle
  task automatic acc_step(input logic [27:0] f);
    logic [27:0] a;
    logic [27:0] d;
    repeat (6) @(posedge clock);
    a = phase_acc;
    @(posedge clock);
    d = phase_acc - a;
    chk({4'h0, d}, {4'h0, f});
  endtask
  // ramp value one edge after the sampled accumulator
  task automatic ramp_chk(input logic [11:0] p);
    logic [27:0] a;
    logic [11:0] s;
    repeat (6) @(posedge clock);
    a = phase_acc;
    @(posedge clock);
    s = a[27:16] + p;
    chk({22'h0, dac_data}, {22'h0, s[11:2]});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = NCO_HSIZE_WORD;
    hwdata = 32'h0;
    comparator_in = 1'b0;
    err_count = 0;
    checked = 0;
    void'($urandom(97441));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    ahb(NCO_HOST_COUNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ahb(32'h0000_000C, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    p0 = 12'($urandom);
    p1 = 12'($urandom);
    send({4'hC, p0});
    send({4'hE, p1});
    send(16'h0002);
    repeat (6) @(posedge clock);
    chk({22'h0, dac_data}, {22'h0, p0[11:2]});
    send(16'h0402);
    repeat (6) @(posedge clock);
    chk({22'h0, dac_data}, {22'h0, p1[11:2]});
    $display("phase test done");
    f0 = 28'($urandom);
    f1 = 28'($urandom);
    send(16'h2000);
    send({2'h1, f0[13:0]});
    acc_step(28'h0);
    send({2'h1, f0[27:14]});
    acc_step(f0);
    $display("full word test done");
    send(16'h1000);
    send({2'h2, f1[27:14]});
    send(16'h0000);
    send({2'h2, f1[13:0]});
    acc_step(f0);
    send(16'h0800);
    acc_step(f1);
    $display("half word test done");
    send(16'h0200);
    ahb(NCO_HOST_PINS_OFS, 1'b1, 32'h1);
    acc_step(f1);
    ahb(NCO_HOST_PINS_OFS, 1'b1, 32'h0);
    acc_step(f0);
    send(16'h0A00);
    acc_step(f0);
    send(16'h0800);
    acc_step(f1);
    send(16'h0202);
    ahb(NCO_HOST_PINS_OFS, 1'b1, 32'h2);
    ramp_chk(p1);
    ahb(NCO_HOST_PINS_OFS, 1'b1, 32'h0);
    ramp_chk(p0);
    $display("select test done");
    for (int i = 0; i < 4; i++)
    begin
      send(16'(i) << 5);
      repeat (4) @(posedge clock);
      chk({31'h0, dac_powerdown}, 32'(i >> 1));
      chk({31'h0, square_out_oe_n}, 32'(~i & 1));
    end
    $display("control test done");
    send(16'h1000);
    send({2'h1, 14'h0200});
    send(16'h0038);
    repeat (4)
    begin
      comparator_in <= 1'($urandom);
      repeat (6) @(posedge clock);
      chk({31'h0, square_out}, {31'h0, comparator_in});
    end
    send(16'h0028);
    repeat (4) @(posedge clock);
    repeat (40)
    begin
      dp = dac_data[NCO_DAC_W-1];
      @(posedge clock);
      chk({31'h0, square_out}, {31'h0, dp});
    end
    send(16'h0020);
    repeat (4) @(posedge clock);
    dp = dac_data[NCO_DAC_W-1];
    r1 = 1'b0;
    r2 = 1'b0;
    sp = square_out;
    for (int i = 0; i < 82; i++)
    begin
      @(posedge clock);
      if (i > 1)
        chk({31'h0, square_out ^ sp}, {31'h0, r2});
      r2 = r1;
      r1 = dac_data[NCO_DAC_W-1] & ~dp;
      dp = dac_data[NCO_DAC_W-1];
      sp = square_out;
    end
    $display("square test done");
    send(16'h0025);
    ahb(NCO_HOST_WORD_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0020);
    send(16'h0022);
    ahb(NCO_HOST_WORD_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0020);
    ahb(NCO_HOST_WORD_OFS, 1'b0, 32'h0);
    chk(rd, {16'h0, sentq[$]});
    ahb(NCO_HOST_COUNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'(sentq.size()));
    $display("count test done");
    tally_and_finish();
  end
endmodule
